// ---- bench/host_model.sv ----
// Purpose: Host side byte access driver
// Assumes: Called at falling edges
// Notes: Released lines show inverted data
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic core_clk,
  output logic wr_stb,
  output logic rd_stb,
  output logic [7:0] addr,
  output logic [7:0] wr_data
);
  initial wr_stb = 1'b0;
  initial rd_stb = 1'b0;
  initial addr = 8'h00;
  initial wr_data = 8'h00;
  task op(input bit w, input [7:0] a, input [7:0] d);
    wr_stb = w;
    rd_stb = !w;
    addr = a;
    wr_data = d;
    @(negedge core_clk);
  endtask
  task idle;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    addr = ~addr;
    wr_data = ~wr_data;
    @(negedge core_clk);
  endtask
endmodule // host_model
`default_nettype wire

// ---- bench/led_regs_asserts.sv ----
// Purpose: Port assertions for led_regs
// Assumes: One clock, rstn async low
// Notes: Bound below
`timescale 1ns/1ps
`default_nettype none
module led_regs_asserts (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_data,
  input wire logic ack_valid,
  input wire logic ack_ok,
  input wire logic [1:0] pump_state,
  input wire logic ext_clk_sel,
  input wire logic [2:0] end_event,
  input wire logic [5:0] op_mode,
  input wire logic [2:0] pc_clear,
  input wire logic irq_pin_out,
  input wire logic irq_pin_oe,
  input wire logic gpo_out
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  wire st = rd_stb && addr == 8'h0c;
  wire sr = wr_stb && addr == 8'h0d;
  wire pin_wr = wr_stb && addr == 8'h0e;
  wire mode_wr = wr_stb && addr == 8'h01;
  sequence quiet_rd; st && end_event == 3'h0; endsequence
  sequence red_end; end_event[2] ##1 !rd_stb ##1 st; endsequence
  pump_field_a: assert property (st |=> rd_data[5:4] == $past(pump_state))
    else $error("pump");
  clock_flag_a: assert property (st |=> rd_data[3] == $past(ext_clk_sel))
    else $error("clock");
  flag_set_a: assert property (red_end |=> rd_data[2]) else $error("set");
  flag_clear_a: assert property (quiet_rd ##1 quiet_rd |=> rd_data[2:0] == 3'h0)
    else $error("clear");
  event_pending_a: assert property (st && end_event[0] ##1 st |=> rd_data[0])
    else $error("pending");
  reset_nack_a: assert property (sr && wr_data == 8'hff |=> ack_valid && !ack_ok)
    else $error("nack");
  write_ack_a: assert property (wr_stb && !(sr && wr_data == 8'hff) |=> ack_valid && ack_ok)
    else $error("ack");
  soft_reset_a: assert property (sr |=> ##1 op_mode == 6'h0 && !gpo_out)
    else $error("reset");
  gpo_level_a: assert property (pin_wr && !$past(sr) |=> ##1 gpo_out == $past(wr_data[1], 2))
    else $error("gpo");
  irq_gpo_a: assert property (pin_wr && !$past(sr) && wr_data[2] |=> ##1
    irq_pin_oe && irq_pin_out == $past(wr_data[0], 2)) else $error("irq gpo");
  irq_int_a: assert property (pin_wr && !$past(sr) && !wr_data[2] |=> ##1 !irq_pin_out)
    else $error("irq int");
  load_clear_a: assert property (mode_wr && !$past(sr) && wr_data[5:4] == 2'h1 |=> pc_clear[2])
    else $error("load");
endmodule // led_regs_asserts
bind led_regs led_regs_asserts u_asserts (
  .core_clk(core_clk),
  .rstn(rstn),
  .wr_stb(wr_stb),
  .rd_stb(rd_stb),
  .addr(addr),
  .wr_data(wr_data),
  .rd_data(rd_data),
  .ack_valid(ack_valid),
  .ack_ok(ack_ok),
  .pump_state(pump_state),
  .ext_clk_sel(ext_clk_sel),
  .end_event(end_event),
  .op_mode(op_mode),
  .pc_clear(pc_clear),
  .irq_pin_out(irq_pin_out),
  .irq_pin_oe(irq_pin_oe),
  .gpo_out(gpo_out)
);
`default_nettype wire

// ---- bench/tb_led_driver_status_reset_gpo_progmem.sv ----
// Purpose: Self-checking bench for led_regs
// Assumes: Inputs change at falling edges
// Notes: Model keeps expected memory bytes
`timescale 1ns/1ps
`default_nettype none
module tb_led_driver_status_reset_gpo_progmem;
  logic core_clk, rstn, wr_stb, rd_stb, ack_valid, ack_ok, ext_clk_sel;
  logic gpo_out, irq_pin_out, irq_pin_oe;
  logic [7:0] addr, wr_data, rd_data;
  logic [1:0] pump_state;
  logic [2:0] end_event, pc_clear;
  logic [5:0] op_mode;
  integer err_total = 0, checks = 0, seed = 32'h0113bb72, i;
  integer mem [0:255];
  host_model host (
    .core_clk(core_clk),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .addr(addr),
    .wr_data(wr_data)
  );
  led_regs uut (
    .core_clk(core_clk),
    .rstn(rstn),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .addr(addr),
    .wr_data(wr_data),
    .rd_data(rd_data),
    .ack_valid(ack_valid),
    .ack_ok(ack_ok),
    .pump_state(pump_state),
    .ext_clk_sel(ext_clk_sel),
    .end_event(end_event),
    .op_mode(op_mode),
    .pc_clear(pc_clear),
    .irq_pin_out(irq_pin_out),
    .irq_pin_oe(irq_pin_oe),
    .gpo_out(gpo_out)
  );
  task chk(input [7:0] got, input [7:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task results;
    if (err_total == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task rd(input [7:0] a, input [7:0] exp);
    host.op(1'b0, a, 8'h00);
    chk(rd_data, exp);
  endtask
  task wr(input [7:0] a, input [7:0] d);
    host.op(1'b1, a, d);
    chk({7'h0, ack_ok}, {7'h0, a != 8'h0d || d != 8'hff});
    chk({7'h0, ack_valid}, 8'h01);
    chk({5'h0, pc_clear}, {5'h0, {3{a == 8'h01}} & {d[5:4] == 2'h1, d[3:2] == 2'h1, d[1:0] == 2'h1}});
    host.idle;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #200000;
    err_total = err_total + 1;
    results;
  end
  initial begin
    rstn = 1'b0;
    pump_state = 2'h0;
    ext_clk_sel = 1'b0;
    end_event = 3'h0;
    repeat (3) @(negedge core_clk);
    rstn = 1'b1;
    rd(8'h0e, 8'h80);
    rd(8'hf0, 8'h00);
    wr(8'h01, 8'h15);
    rd(8'h01, 8'h15);
    for (i = 8'h10; i < 8'h70; i = i + 1) begin
      mem[i] = $random(seed) & 8'hff;
      wr(i[7:0], mem[i][7:0]);
    end
    for (i = 8'h10; i < 8'h70; i = i + 1) rd(i[7:0], mem[i][7:0]);
    for (i = 0; i < 8; i = i + 1) begin
      {pump_state, ext_clk_sel} = i[2:0];
      rd(8'h0c, {2'h0, i[2:0], 3'h0});
    end
    end_event = 3'h5;
    host.idle;
    end_event = 3'h0;
    host.idle;
    chk({6'h0, irq_pin_oe, irq_pin_out}, 8'h02);
    rd(8'h0c, 8'h3d);
    chk({7'h0, irq_pin_oe}, 8'h00);
    end_event = 3'h1;
    rd(8'h0c, 8'h38);
    end_event = 3'h0;
    rd(8'h0c, 8'h39);
    rd(8'h0c, 8'h38);
    for (i = 0; i < 8; i = i + 1) begin
      wr(8'h0e, i[7:0]);
      chk({5'h0, gpo_out, irq_pin_oe, irq_pin_out}, {5'h0, i[1], i[2], i[0] & i[2]});
      rd(8'h0e, 8'h80 | i[7:0]);
    end
    wr(8'h0d, 8'h55);
    host.idle;
    rd(8'h0e, 8'h80);
    rd(8'h10, 8'h00);
    wr(8'h01, 8'h15);
    wr(8'h0e, 8'h02);
    wr(8'h0d, 8'hff);
    chk({5'h0, pc_clear}, 8'h07);
    host.idle;
    chk({gpo_out, 1'b0, op_mode}, 8'h00);
    results;
  end
endmodule // tb_led_driver_status_reset_gpo_progmem
`default_nettype wire

// ---- hdl/led_regs.v ----
// Purpose: Status, soft reset, pin control and program memory registers
// Assumes: An I2C front end hands over decoded byte reads and writes
// Notes: ack_valid/ack_ok answer each write one cycle later
`timescale 1ns/1ps
`default_nettype none
`include "led_slice_regs.vh"
module led_regs #(
  parameter [0:0] VARIANT = 1'b1 // Arbitrary value
) (
  input wire core_clk,
  input wire rstn,
  input wire wr_stb,
  input wire rd_stb,
  input wire [7:0] addr,
  input wire [7:0] wr_data,
  output reg [7:0] rd_data,
  output reg ack_valid,
  output reg ack_ok,
  input wire [1:0] pump_state,
  input wire ext_clk_sel,
  input wire [2:0] end_event,
  output reg [5:0] op_mode,
  output reg [2:0] pc_clear,
  output reg irq_pin_out,
  output reg irq_pin_oe,
  output reg gpo_out
);
  // ----------------------------------------
  // Decode functions
  // ----------------------------------------
  localparam [2:0] SRC_NONE = 3'h0;
  localparam [2:0] SRC_STATUS = 3'h1;
  localparam [2:0] SRC_PIN = 3'h2;
  localparam [2:0] SRC_MODE = 3'h3;
  localparam [2:0] SRC_RED = 3'h4;
  localparam [2:0] SRC_GREEN = 3'h5;
  localparam [2:0] SRC_BLUE = 3'h6;

  function in_range;
    input [7:0] a;
    input [7:0] base;
    begin
      in_range = (a >= base) && (a <= base + 8'h1f);
    end
  endfunction

  // Byte index inside one channel window
  function [4:0] mem_index;
    input [7:0] a;
    input [7:0] base;
    reg [7:0] offset;
    begin
      offset = a - base;
      mem_index = offset[4:0];
    end
  endfunction

  // One bit per channel whose mode selects load
  function [2:0] load_decode;
    input [7:0] data;
    begin
      load_decode[2] = (data[5:4] == `MODE_LOAD);
      load_decode[1] = (data[3:2] == `MODE_LOAD);
      load_decode[0] = (data[1:0] == `MODE_LOAD);
    end
  endfunction

  // Pump state, clock source and channel flags
  function [7:0] status_byte;
    input [1:0] pump;
    input ext_clk;
    input [2:0] flags;
    begin
      status_byte = {2'b00, pump, ext_clk, flags};
    end
  endfunction

  // Soft reset value that is not acknowledged
  function is_nack;
    input [7:0] data;
    begin
      is_nack = (data == `NACK_VALUE); // R6
    end
  endfunction

  // Which register a read returns
  function [2:0] read_source;
    input [7:0] a;
    begin
      if (a == `STATUS_ADDR) begin
        read_source = SRC_STATUS;
      end else if (a == `PIN_CTRL_ADDR) begin
        read_source = SRC_PIN;
      end else if (a == `OPMODE_ADDR) begin
        read_source = SRC_MODE;
      end else if (in_range(a, `RED_MEM_BASE)) begin
        read_source = SRC_RED;
      end else if (in_range(a, `GREEN_MEM_BASE)) begin
        read_source = SRC_GREEN;
      end else if (in_range(a, `BLUE_MEM_BASE)) begin
        read_source = SRC_BLUE;
      end else begin
        read_source = SRC_NONE;
      end
    end
  endfunction

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  wire hit_red = in_range(addr, `RED_MEM_BASE); // R11 R12
  wire hit_green = in_range(addr, `GREEN_MEM_BASE); // R13
  wire hit_blue = in_range(addr, `BLUE_MEM_BASE); // R14
  wire [4:0] red_idx = mem_index(addr, `RED_MEM_BASE); // R11 R12
  wire [4:0] green_idx = mem_index(addr, `GREEN_MEM_BASE); // R13
  wire [4:0] blue_idx = mem_index(addr, `BLUE_MEM_BASE); // R14
  wire red_wr = wr_stb && hit_red;
  wire green_wr = wr_stb && hit_green;
  wire blue_wr = wr_stb && hit_blue;
  wire soft_reset_hit = wr_stb && (addr == `SOFT_RESET_ADDR);
  wire mode_write = wr_stb && (addr == `OPMODE_ADDR);
  wire pin_write = wr_stb && (addr == `PIN_CTRL_ADDR);
  wire status_read = rd_stb && (addr == `STATUS_ADDR);
  wire [2:0] rd_src = read_source(addr);

  // ----------------------------------------
  // Registers and next values
  // ----------------------------------------
  reg soft_clear_reg;
  reg soft_clear_next;
  reg [2:0] flags_reg;
  reg [2:0] flags_next;
  reg [6:0] pin_ctrl_reg;
  reg [6:0] pin_ctrl_next;
  reg [5:0] op_mode_next;
  reg [2:0] pc_clear_next;
  reg ack_valid_next;
  reg ack_ok_next;
  reg gpo_next;
  reg irq_out_next;
  reg irq_oe_next;
  reg [7:0] rd_data_next;
  wire [7:0] red_rd;
  wire [7:0] green_rd;
  wire [7:0] blue_rd;

  // ----------------------------------------
  // Program memories
  // ----------------------------------------
  prog_memory #(.DEPTH(16)) u_red (
    .core_clk(core_clk),
    .rstn(rstn),
    .clear(soft_clear_reg),
    .wr_en(red_wr),
    .byte_idx(red_idx),
    .wr_data(wr_data),
    .rd_data(red_rd)
  );
  prog_memory #(.DEPTH(16)) u_green (
    .core_clk(core_clk),
    .rstn(rstn),
    .clear(soft_clear_reg),
    .wr_en(green_wr),
    .byte_idx(green_idx),
    .wr_data(wr_data),
    .rd_data(green_rd)
  );
  prog_memory #(.DEPTH(16)) u_blue (
    .core_clk(core_clk),
    .rstn(rstn),
    .clear(soft_clear_reg),
    .wr_en(blue_wr),
    .byte_idx(blue_idx),
    .wr_data(wr_data),
    .rd_data(blue_rd)
  );

  // ----------------------------------------
  // Soft reset and acknowledge next values
  // ----------------------------------------
  always @* begin
    soft_clear_next = soft_reset_hit; // R5
    ack_valid_next = wr_stb;
    ack_ok_next = 1'b1; // R7
    if (soft_reset_hit && is_nack(wr_data)) begin
      ack_ok_next = 1'b0; // R6
    end
  end

  // ----------------------------------------
  // Mode and pin control next values
  // ----------------------------------------
  always @* begin
    op_mode_next = op_mode;
    pc_clear_next = 3'b000;
    pin_ctrl_next = pin_ctrl_reg;
    if (soft_clear_reg) begin
      op_mode_next = 6'h00; // R5
      pc_clear_next = 3'b111;
      pin_ctrl_next = `PIN_CTRL_RESET; // R5
    end else begin
      if (mode_write) begin
        op_mode_next = wr_data[5:0]; // R15
        pc_clear_next = load_decode(wr_data); // R15
      end
      if (pin_write) begin
        pin_ctrl_next = wr_data[6:0]; // R8 R9
      end
    end
  end

  // ----------------------------------------
  // Event flags next value
  // ----------------------------------------
  always @* begin
    if (soft_clear_reg || status_read) begin
      flags_next = end_event; // R3 R16
    end else begin
      flags_next = flags_reg | end_event; // R3
    end
  end

  // ----------------------------------------
  // Pin next values
  // ----------------------------------------
  always @* begin
    gpo_next = pin_ctrl_reg[`PIN_GPO_BIT]; // R9
    irq_out_next = 1'b0; // R8
    irq_oe_next = |flags_next; // R4
    if (soft_clear_reg) begin
      gpo_next = 1'b0; // R5
    end else if (pin_ctrl_reg[`PIN_SEL_BIT]) begin
      irq_out_next = pin_ctrl_reg[`PIN_IRQ_BIT]; // R8 R9
      irq_oe_next = 1'b1;
    end
  end

  // ----------------------------------------
  // Read data next value
  // ----------------------------------------
  always @* begin
    rd_data_next = rd_data;
    if (rd_stb) begin
      case (rd_src)
        SRC_STATUS: rd_data_next = status_byte(pump_state, ext_clk_sel, flags_reg); // R1 R2 R3
        SRC_PIN: rd_data_next = {VARIANT, pin_ctrl_reg};
        SRC_MODE: rd_data_next = {2'b00, op_mode};
        SRC_RED: rd_data_next = red_rd; // R11 R12
        SRC_GREEN: rd_data_next = green_rd; // R13
        SRC_BLUE: rd_data_next = blue_rd; // R14
        default: rd_data_next = 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      soft_clear_reg <= 1'b0;
    end else begin
      soft_clear_reg <= soft_clear_next; // R5
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ack_valid <= 1'b0;
    end else begin
      ack_valid <= ack_valid_next;
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ack_ok <= 1'b0;
    end else begin
      ack_ok <= ack_ok_next; // R6 R7
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= rd_data_next;
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      op_mode <= 6'h00;
    end else begin
      op_mode <= op_mode_next; // R15
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pc_clear <= 3'b000;
    end else begin
      pc_clear <= pc_clear_next; // R15
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pin_ctrl_reg <= `PIN_CTRL_RESET;
    end else begin
      pin_ctrl_reg <= pin_ctrl_next;
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      flags_reg <= 3'b000;
    end else begin
      flags_reg <= flags_next; // R3 R16
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      gpo_out <= 1'b0;
    end else begin
      gpo_out <= gpo_next; // R9
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irq_pin_out <= 1'b0;
    end else begin
      irq_pin_out <= irq_out_next; // R8
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irq_pin_oe <= 1'b0;
    end else begin
      irq_pin_oe <= irq_oe_next; // R4
    end
  end
endmodule // led_regs
`default_nettype wire

// ---- hdl/prog_memory.v ----
// Purpose: One channel's sixteen two-byte program store
// Assumes: Byte index 0..31, even byte is the high half
// Notes: Cleared by soft reset
`timescale 1ns/1ps
`default_nettype none
module prog_memory #(
  parameter DEPTH = 16
) (
  input wire core_clk,
  input wire rstn,
  input wire clear,
  input wire wr_en,
  input wire [4:0] byte_idx,
  input wire [7:0] wr_data,
  output wire [7:0] rd_data
);
  reg [15:0] mem [0:DEPTH-1];
  integer i;
  wire [3:0] word = byte_idx[4:1];
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (i = 0; i < DEPTH; i = i + 1)
        mem[i] <= 16'h0000;
    end else if (clear) begin
      for (i = 0; i < DEPTH; i = i + 1)
        mem[i] <= 16'h0000;
    end else if (wr_en) begin
      if (!byte_idx[0])
        mem[word][15:8] <= wr_data; // R10
      else
        mem[word][7:0] <= wr_data; // R10
    end
  end
  assign rd_data = byte_idx[0] ? mem[word][7:0] : mem[word][15:8]; // R10
endmodule // prog_memory
`default_nettype wire

// ---- pkg/led_slice_regs.vh ----
// Purpose: Register map constants for the LED driver register slice
// Assumes: Byte-wide register space reached through an I2C byte port
// Notes: Byte addresses, bit positions and reset values
// Operation
// R1 - Pump status field encodes pump operating state
// R2 - Clock flag 0 internal, 1 external
// R3 - Channel flags set on end, clear on read
// R4 - Status read releases open-drain interrupt pin
// R5 - Soft reset write restores every register default
// R6 - Value 0xff to soft reset is nacked
// R7 - Other soft reset values are acked
// R8 - Select bit picks interrupt or general output
// R9 - Output pins follow their value bits
// R10 - Instruction high byte at lower address
// R11 - Red high byte at 0x10 plus 2n
// R12 - Red low byte at 0x11 plus 2n
// R13 - Green bytes at 0x30/0x31 plus 2n
// R14 - Blue bytes at 0x50/0x51 plus 2n
// R15 - Mode 01 loads program, clears counter
// R16 - Event during status read stays pending
// R17 - Host writes memory only in load mode; the code accepts memory writes in every mode
`ifndef LED_SLICE_REGS_VH
`define LED_SLICE_REGS_VH
`define OPMODE_ADDR 8'h01
`define STATUS_ADDR 8'h0c
`define SOFT_RESET_ADDR 8'h0d
`define PIN_CTRL_ADDR 8'h0e
`define RED_MEM_BASE 8'h10
`define GREEN_MEM_BASE 8'h30
`define BLUE_MEM_BASE 8'h50
`define MEM_END 8'h6f
`define NACK_VALUE 8'hff
`define MODE_LOAD 2'h1
`define PIN_CTRL_RESET 7'h00
`define PIN_SEL_BIT 2
`define PIN_GPO_BIT 1
`define PIN_IRQ_BIT 0
`endif
